// file: common/cmrc_pkg.sv
// Package: constants and carrier types for the memory request controller
// Operation
// R1: Same-cycle priority: jump, exchange, bulk, peripheral, processor
// R2: Serve addresses strictly in arrival order
// R3: Broadcast address; only selected bank accepts
// R4: Busy bank: hold address, retry until free
// R5: Processor waits until buffered reference accepted
// R6: Other processor proceeds to free banks
// R7: Same bank same cycle: processor zero first
// R8: Two-entry stack; full stalls increment issue (code stalls only in the integrated variant)
// R9: Stall holds until stack fully drained
// R10: Bulk transfers never cause the stall
// R11: Sixteen busy flags, set on go
// R12: Sixteen reservation flags set by bulk transfer
// R13: Every reference tagged with its port
// R14: Check address parity; peripheral only integrated (code also checks the exchange ports in the integrated variant)
// R15: Check write, generate read parity (code skips the processor write check in the integrated variant)
// R16: Generate parity on every bank address
// R17: Parity mode: generate and check data parity
// R18: Step address word by word for sequences
// R19: Correcting mode stores 8 check bits
// R20: Busy flag clears when bank cycle ends
package cmrc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NBANK    = 16;
  localparam int BANK_W   = 4;
  localparam int ADDR_W   = 18;
  localparam int DATA_W   = 60;
  localparam int CHK_W    = 8;
  localparam int NSRC     = 10;
  localparam int TAG_W    = 4;
  localparam int STACK_N  = 2;
  localparam int CNT_W    = 11;

  // ----------------------------------------------------------------
  // Source tags, in priority order (index 0 highest)
  // ----------------------------------------------------------------
  localparam logic [TAG_W-1:0] TAG_XJ0   = 4'h0;
  localparam logic [TAG_W-1:0] TAG_XJ1   = 4'h1;
  localparam logic [TAG_W-1:0] TAG_PX0   = 4'h2;
  localparam logic [TAG_W-1:0] TAG_PX1   = 4'h3;
  localparam logic [TAG_W-1:0] TAG_BS0   = 4'h4;
  localparam logic [TAG_W-1:0] TAG_BS1   = 4'h5;
  localparam logic [TAG_W-1:0] TAG_PRW0  = 4'h6;
  localparam logic [TAG_W-1:0] TAG_PRW1  = 4'h7;
  localparam logic [TAG_W-1:0] TAG_CP0   = 4'h8;
  localparam logic [TAG_W-1:0] TAG_CP1   = 4'h9;

  // Reset values
  localparam logic [NBANK-1:0] BUSY_RST  = 16'h0000;
  localparam logic [NBANK-1:0] RSV_RST   = 16'h0000;

  // Memory operating modes
  typedef enum logic [1:0] {
    CMRC_MODE_PARITY  = 2'h0,
    CMRC_MODE_CORRECT = 2'h1
  } cmrc_mode_t;

  // One request from a port
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic              addr_par;
    logic [DATA_W-1:0] wdata;
    logic              data_par;
    logic [CNT_W-1:0]  count;   // Words after the first for sequences, 0 = single
  } cmrc_req_t;

  // One reference toward the banks
  typedef struct packed {
    logic              go;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic              addr_par;
    logic [TAG_W-1:0]  tag;
    logic [DATA_W-1:0] wdata;
    logic [CHK_W-1:0]  check;
  } cmrc_mem_t;

  // Read data back from the banks
  typedef struct packed {
    logic              valid;
    logic [TAG_W-1:0]  tag;
    logic [DATA_W-1:0] rdata;
    logic [CHK_W-1:0]  check;
  } cmrc_rd_t;

  // Read data toward a port
  typedef struct packed {
    logic              valid;
    logic [TAG_W-1:0]  tag;
    logic [DATA_W-1:0] rdata;
    logic              data_par;
  } cmrc_ret_t;

endpackage

// file: hw/cmrc_memory_request_controller.sv
// Memory request controller: arbitration, bank busy and parity
`timescale 1ns/100ps
`default_nettype none
module cmrc_memory_request_controller (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rstn_i,
  // Configuration straps
  input  wire logic                          integrated_i,
  input  wire cmrc_pkg::cmrc_mode_t          mode_i,
  // Requests, indexed by source tag
  input  wire cmrc_pkg::cmrc_req_t [9:0]     req_i,
  output logic [9:0]                         grant_o,
  // Bank side
  output cmrc_pkg::cmrc_mem_t                mem_o,
  input  wire logic [15:0]                   bank_done_i,
  input  wire cmrc_pkg::cmrc_rd_t            mem_rd_i,
  // Return path to ports
  output cmrc_pkg::cmrc_ret_t                ret_o,
  // Status
  output logic                               inc_stall_o,
  output logic                               addr_perr_o,
  output logic                               data_perr_o,
  output logic                               rd_perr_o
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Odd parity over an address
  function automatic logic apar(input logic [17:0] a);
    apar = ~(^a);
  endfunction

  // Bank number of an address: low bits interleave
  function automatic logic [3:0] bank_of(input logic [17:0] a);
    bank_of = a[3:0];
  endfunction

  // Simple check bits: parity over eight data slices
  function automatic logic [7:0] chk_gen(input logic [59:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 60; i++) begin
      c[i % 8] = c[i % 8] ^ d[i];
    end
    chk_gen = c;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0]                busy_reg;
  logic [15:0]                rsv_reg;
  // Held reference per source; one buffer each keeps arrival order
  cmrc_pkg::cmrc_req_t [9:0]  hold_reg;
  logic [9:0]                 hold_vld_reg;
  logic [1:0]                 stk_cnt_reg;
  logic                       stall_reg;
  logic [1:0]                 mode_s1_reg;
  logic [1:0]                 mode_s2_reg;
  logic                       integ_s1_reg;
  logic                       integ_s2_reg;

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // Candidate per source: buffered entry first, else fresh request
  cmrc_pkg::cmrc_req_t [9:0]  cand;
  logic [9:0]                 cand_ok;
  logic [9:0]                 win_oh;
  logic [3:0]                 win_idx;
  logic                       win_any;
  logic [15:0]                bsy_eff;

  assign bsy_eff = busy_reg & ~bank_done_i;                   // R20

  always_comb begin
    for (int i = 0; i < 10; i++) begin
      cand[i]    = hold_vld_reg[i] ? hold_reg[i] : req_i[i];    // R2 R5
      cand[i].valid = hold_vld_reg[i] | req_i[i].valid;
      // Only free banks may accept; others keep waiting
      cand_ok[i] = cand[i].valid
                 & ~bsy_eff[bank_of(cand[i].addr)]              // R3 R4 R6
                 & (~rsv_reg[bank_of(cand[i].addr)]
                    | (i == 4) | (i == 5));                     // R12
    end
  end

  // Fixed priority: lowest index wins; index order is class order
  always_comb begin
    win_oh  = 10'h000;
    win_idx = 4'h0;
    win_any = 1'b0;
    for (int i = 9; i >= 0; i--) begin
      if (cand_ok[i]) begin
        win_idx = 4'(i);                                        // R1 R7
        win_any = 1'b1;
      end
    end
    if (win_any) begin
      win_oh[win_idx] = 1'b1;
    end
  end

  // A fresh request is taken when it wins or when it is buffered
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      grant_o[i] = req_i[i].valid & ~hold_vld_reg[i];           // R5
    end
  end

  // ----------------------------------------------------------------
  // Parity checks on port inputs
  // ----------------------------------------------------------------
  logic                       chk_addr;
  logic                       chk_data;
  cmrc_pkg::cmrc_req_t        win;
  logic                       aerr;
  logic                       derr;

  assign win      = cand[win_idx];
  // Integrated variant checks address parity only on the exchange and peripheral ports
  assign chk_addr = ~integ_s2_reg | (win_idx >= 4'h2 && win_idx <= 4'h3)
                  | (win_idx == 4'h6) | (win_idx == 4'h7);      // R14
  assign chk_data = ~integ_s2_reg | (win_idx < 4'h8);           // R15
  assign aerr     = win_any & chk_addr & (apar(win.addr) != win.addr_par);
  assign derr     = win_any & win.write & chk_data
                  & ((^win.wdata) == win.data_par);             // R15

  // ----------------------------------------------------------------
  // Sequences and stack
  // ----------------------------------------------------------------
  logic                       seq_src;
  logic                       cp_blocked;
  logic [1:0]                 cp_waiting;
  logic                       bulk_act;

  // Jump packages, exchange and bulk transfers step word by word
  assign seq_src  = (win_idx <= 4'h5) && (win.count != '0);     // R18
  assign bulk_act = hold_vld_reg[4] | hold_vld_reg[5];
  // Processor entries left waiting this cycle form the stack
  assign cp_waiting = 2'(hold_vld_reg[8] & ~win_oh[8])
                    + 2'(hold_vld_reg[9] & ~win_oh[9]);
  assign cp_blocked = (req_i[8].valid & hold_vld_reg[8])
                    | (req_i[9].valid & hold_vld_reg[9]);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Strap synchronisers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_s1_reg  <= 2'h0;
      mode_s2_reg  <= 2'h0;
      integ_s1_reg <= 1'b0;
      integ_s2_reg <= 1'b0;
    end else begin
      mode_s1_reg  <= mode_i;
      mode_s2_reg  <= mode_s1_reg;
      integ_s1_reg <= integrated_i;
      integ_s2_reg <= integ_s1_reg;
    end
  end

  // Hold buffers: keep losers, step sequences
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hold_vld_reg <= 10'h000;
      hold_reg     <= '0;
    end else begin
      for (int i = 0; i < 10; i++) begin
        if (win_oh[i] && seq_src) begin
          hold_vld_reg[i]   <= 1'b1;
          hold_reg[i]       <= cand[i];
          hold_reg[i].addr  <= cand[i].addr + 18'h00001;        // R18
          hold_reg[i].count <= cand[i].count - 11'h001;
        end else if (win_oh[i]) begin
          hold_vld_reg[i] <= 1'b0;
        end else if (cand[i].valid) begin
          hold_vld_reg[i] <= 1'b1;                              // R4
          hold_reg[i]     <= cand[i];
        end
      end
    end
  end

  // Bank busy and reservation flags
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_reg <= cmrc_pkg::BUSY_RST;
      rsv_reg  <= cmrc_pkg::RSV_RST;
    end else begin
      busy_reg <= bsy_eff | (win_any ? (16'h0001 << bank_of(win.addr))
                                     : 16'h0000);              // R11
      if (bulk_act) begin
        // Reserve the next bank of each running transfer
        rsv_reg <= (hold_vld_reg[4] ?
                    (16'h0001 << bank_of(hold_reg[4].addr)) : 16'h0000)
                 | (hold_vld_reg[5] ?
                    (16'h0001 << bank_of(hold_reg[5].addr)) : 16'h0000);
      end else begin
        rsv_reg <= 16'h0000;                                    // R12
      end
    end
  end

  // Increment issue stall
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stk_cnt_reg <= 2'h0;
      stall_reg   <= 1'b0;
    end else begin
      stk_cnt_reg <= cp_waiting;
      if (integ_s2_reg && !bulk_act
          && (cp_waiting == 2'(cmrc_pkg::STACK_N) || cp_blocked)) begin
        stall_reg <= 1'b1;                                      // R8 R10
      end else if (cp_waiting == 2'h0) begin
        stall_reg <= 1'b0;                                      // R9
      end
    end
  end

  // Bank reference and port return
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mem_o       <= '0;
      ret_o       <= '0;
      addr_perr_o <= 1'b0;
      data_perr_o <= 1'b0;
      rd_perr_o   <= 1'b0;
    end else begin
      mem_o.go       <= win_any;
      mem_o.write    <= win.write;
      mem_o.addr     <= win.addr;                               // R3
      mem_o.addr_par <= apar(win.addr);                         // R16
      mem_o.tag      <= win_idx;                                // R13
      mem_o.wdata    <= win.wdata;
      mem_o.check    <= (mode_s2_reg == 2'(cmrc_pkg::CMRC_MODE_CORRECT))
                      ? chk_gen(win.wdata)                      // R19
                      : {7'h00, ~(^win.wdata)};                 // R17
      addr_perr_o    <= aerr;
      data_perr_o    <= derr;
      ret_o.valid    <= mem_rd_i.valid;
      ret_o.tag      <= mem_rd_i.tag;
      ret_o.rdata    <= mem_rd_i.rdata;
      ret_o.data_par <= ~(^mem_rd_i.rdata);                     // R15
      rd_perr_o      <= mem_rd_i.valid
                      & (mode_s2_reg == 2'(cmrc_pkg::CMRC_MODE_PARITY))
                      & (mem_rd_i.check[0] != ~(^mem_rd_i.rdata)); // R17
    end
  end

  assign inc_stall_o = stall_reg;                               // R8

endmodule
`default_nettype wire

// file: test/cmrc_monitor.sv
// Port checker for the memory request controller
`timescale 1ns/100ps
`default_nettype none
module cmrc_monitor (
  // Clock, reset and straps
  input wire logic                      clk_i,
  input wire logic                      rstn_i,
  input wire logic                      integrated_i,
  input wire cmrc_pkg::cmrc_mode_t      mode_i,
  // Request side
  input wire cmrc_pkg::cmrc_req_t [9:0] req_i,
  input wire logic [9:0]                grant_o,
  // Bank and return side
  input wire cmrc_pkg::cmrc_mem_t       mem_o,
  input wire logic [15:0]               bank_done_i,
  input wire cmrc_pkg::cmrc_rd_t        mem_rd_i,
  input wire cmrc_pkg::cmrc_ret_t       ret_o,
  // Status
  input wire logic                      inc_stall_o,
  input wire logic                      addr_perr_o,
  input wire logic                      data_perr_o,
  input wire logic                      rd_perr_o
);
  logic [9:0] vld;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Valid bits of all sources
  always_comb for (int k = 0; k < 10; k++) vld[k] = req_i[k].valid;
  property p_addr_par; mem_o.go |-> mem_o.addr_par == ~^mem_o.addr; endproperty
  a_addr_par: assert property (p_addr_par)
    else $error("bank address parity wrong");
  property p_tag; mem_o.go |-> mem_o.tag < 4'ha; endproperty
  a_tag: assert property (p_tag)
    else $error("reference tag out of range");
  property p_grant; (grant_o & ~vld) == 10'h000; endproperty
  a_grant: assert property (p_grant)
    else $error("grant without a request");
  property p_ret;
    mem_rd_i.valid |=> ret_o.valid && ret_o.tag == $past(mem_rd_i.tag)
      && ret_o.data_par == ~^ret_o.rdata;
  endproperty
  a_ret: assert property (p_ret)
    else $error("return data or parity wrong");
  property p_busy;
    mem_o.go && !bank_done_i[mem_o.addr[3:0]] |=>
      !(mem_o.go && mem_o.addr[3:0] == $past(mem_o.addr[3:0]));
  endproperty
  a_busy: assert property (p_busy)
    else $error("go sent to a busy bank");
  property p_stall_off; !integrated_i [*4] |-> !inc_stall_o; endproperty
  a_stall_off: assert property (p_stall_off)
    else $error("stall outside integrated variant");
  property p_aperr;
    grant_o[6] && req_i[6].addr_par == ^req_i[6].addr |=> addr_perr_o;
  endproperty
  a_aperr: assert property (p_aperr)
    else $error("address parity error missed");
  property p_dperr;
    grant_o[6] && req_i[6].write && req_i[6].data_par == ^req_i[6].wdata
      |=> data_perr_o;
  endproperty
  a_dperr: assert property (p_dperr)
    else $error("write parity error missed");
  property p_rdperr;
    mem_rd_i.valid && mode_i == cmrc_pkg::CMRC_MODE_PARITY
      && mem_rd_i.check[0] == ^mem_rd_i.rdata |=> rd_perr_o;
  endproperty
  a_rdperr: assert property (p_rdperr)
    else $error("read parity error missed");
endmodule
bind cmrc_memory_request_controller cmrc_monitor i_cmrc_monitor (
  .clk_i(clk_i), .rstn_i(rstn_i), .integrated_i(integrated_i),
  .mode_i(mode_i), .req_i(req_i), .grant_o(grant_o), .mem_o(mem_o),
  .bank_done_i(bank_done_i), .mem_rd_i(mem_rd_i), .ret_o(ret_o),
  .inc_stall_o(inc_stall_o), .addr_perr_o(addr_perr_o),
  .data_perr_o(data_perr_o), .rd_perr_o(rd_perr_o));
`default_nettype wire

// file: test/cmrc_bank_model.sv
// Behavioural model of sixteen interleaved memory banks
`timescale 1ns/100ps
`default_nettype none
module cmrc_bank_model (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rstn_i,
  // Reference in, cycle length, read parity corruption
  input  wire cmrc_pkg::cmrc_mem_t mem_i,
  input  wire logic [7:0]          lat_i,
  input  wire logic                bad_i,
  // Completion and read data out
  output logic [15:0]              done_o,
  output cmrc_pkg::cmrc_rd_t       rd_o
);
  logic [7:0]  cnt [16];
  logic [3:0]  tg [16];
  logic [17:0] ad [16];
  logic        rq [16];
  // Per bank cycle timer; idle read lines toggle
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_o <= '0;
      rd_o <= '0;
      for (int b = 0; b < 16; b++) cnt[b] <= 8'h00;
    end else begin
      done_o <= '0;
      rd_o.valid <= 1'b0;
      rd_o.rdata <= ~rd_o.rdata;
      for (int b = 0; b < 16; b++) begin
        if (cnt[b] == 8'h01) begin
          done_o[b] <= 1'b1;
          if (rq[b]) begin
            rd_o.valid <= 1'b1;
            rd_o.tag <= tg[b];
            rd_o.rdata <= {42'h0, ad[b]};
            rd_o.check <= {7'h00, (~^ad[b]) ^ bad_i};
          end
        end
        if (cnt[b] != 8'h00) cnt[b] <= cnt[b] - 8'h01;
        if (mem_i.go && mem_i.addr[3:0] == b[3:0]) begin
          cnt[b] <= lat_i;
          tg[b] <= mem_i.tag;
          ad[b] <= mem_i.addr;
          rq[b] <= !mem_i.write;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: test/cmrc_memory_request_controller_tb.sv
// Testbench for the memory request controller
`timescale 1ns/100ps
`default_nettype none
module cmrc_memory_request_controller_tb;
  logic                      clk = 1'b0;
  logic                      rstn = 1'b0;
  logic                      integ = 1'b0;
  cmrc_pkg::cmrc_mode_t      mode = cmrc_pkg::CMRC_MODE_PARITY;
  logic                      bad = 1'b0;
  logic [7:0]                lat = 8'h04;
  cmrc_pkg::cmrc_req_t [9:0] req = '0;
  logic [9:0]                grant;
  cmrc_pkg::cmrc_mem_t       mem;
  logic [15:0]               done;
  cmrc_pkg::cmrc_rd_t        rd;
  cmrc_pkg::cmrc_ret_t       ret;
  logic                      stall, aperr, dperr, rperr;
  logic [2:0]                pe = '0;
  int                        num_errors = 0, cmp_count = 0, cyc = 0;
  cmrc_pkg::cmrc_mem_t       gq[$];
  cmrc_memory_request_controller i_cmrc_memory_request_controller (
    .clk_i(clk), .rstn_i(rstn), .integrated_i(integ),
    .mode_i(mode), .req_i(req), .grant_o(grant),
    .mem_o(mem), .bank_done_i(done), .mem_rd_i(rd), .ret_o(ret),
    .inc_stall_o(stall), .addr_perr_o(aperr), .data_perr_o(dperr),
    .rd_perr_o(rperr));
  cmrc_bank_model i_cmrc_bank_model (.clk_i(clk), .rstn_i(rstn),
    .mem_i(mem), .lat_i(lat), .bad_i(bad), .done_o(done), .rd_o(rd));
  // 40 MHz clock
  initial forever #12.5 clk = ~clk;
  // Log references to the banks and sticky error flags
  always @(negedge clk) begin
    if (mem.go === 1'b1) gq.push_back(mem);
    pe <= pe | {aperr, dperr, rperr};
  end
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic cmrc_pkg::cmrc_req_t mk(logic [17:0] a, logic w,
                                             logic [10:0] c);
    mk = '0;
    mk.valid = 1'b1;
    mk.write = w;
    mk.addr = a;
    mk.addr_par = ~^a;
    mk.wdata = {42'h0, a};
    mk.data_par = ~^a;
    mk.count = c;
  endfunction
  // Released request lines show inverted values
  function automatic cmrc_pkg::cmrc_req_t off(cmrc_pkg::cmrc_req_t r);
    off = ~r;
    off.valid = 1'b0;
  endfunction
  task automatic put(int i, cmrc_pkg::cmrc_req_t r);
    int n;
    n = 0;
    @(negedge clk);
    req[i] = r;
    #1;
    while (grant[i] !== 1'b1 && n < 400) begin
      @(negedge clk);
      #1;
      n++;
    end
    // A request never taken counts as a mismatch
    if (n >= 400) num_errors++;
    @(negedge clk);
    req[i] = off(r);
  endtask
  task automatic wait_go(int n);
    for (int k = 0; k < 300 && gq.size() < n; k++) @(negedge clk);
  endtask
  // All ten sources at once; processors share one bank
  task automatic t_prio();
    gq.delete();
    @(negedge clk);
    for (int i = 0; i < 10; i++) req[i] = mk(18'(i == 9 ? 8 : i), 1'b0, '0);
    #1;
    chk("grant all", 32'(grant), 32'h3ff);
    @(negedge clk);
    for (int i = 0; i < 10; i++) req[i] = off(req[i]);
    wait_go(10);
    for (int k = 0; k < 10; k++) begin
      chk("tag", 32'(gq[k].tag), k);
      chk("addr", 32'(gq[k].addr), k == 9 ? 8 : k);
    end
    repeat (8) @(negedge clk);
    chk("no error", 32'(pe), 0);
  endtask
  // Bulk sequence of four words steps the address
  task automatic t_seq();
    gq.delete();
    put(4, mk(18'h20, 1'b0, 11'h3));
    wait_go(4);
    chk("words", gq.size(), 4);
    for (int k = 0; k < 4; k++) chk("seq", 32'(gq[k].addr), 32'h20 + k);
  endtask
  // Bad address, write and read parity are all flagged
  task automatic t_perr();
    cmrc_pkg::cmrc_req_t r;
    r = mk(18'h2a, 1'b1, '0);
    r.addr_par = ~r.addr_par;
    r.data_par = ~r.data_par;
    @(negedge clk);
    #1 pe = '0;
    bad = 1'b1;
    put(6, r);
    put(6, mk(18'h2b, 1'b0, '0));
    repeat (12) @(negedge clk);
    chk("error flags", 32'(pe), 32'h7);
    bad = 1'b0;
  endtask
  // Check bits toward the banks in both memory modes
  task automatic t_ecc();
    mode = cmrc_pkg::CMRC_MODE_CORRECT;
    repeat (4) @(negedge clk);
    gq.delete();
    put(6, mk(18'h35, 1'b1, '0));
    wait_go(1);
    chk("slice check", 32'(gq[0].check), 32'h35);
    mode = cmrc_pkg::CMRC_MODE_PARITY;
    repeat (4) @(negedge clk);
    gq.delete();
    put(6, mk(18'h35, 1'b1, '0));
    wait_go(1);
    chk("parity check", 32'(gq[0].check), 32'h01);
  endtask
  // Busy bank: buffering, other processor proceeds, stall and drain
  task automatic t_bank();
    integ = 1'b1;
    lat = 8'h0c;
    repeat (4) @(negedge clk);
    gq.delete();
    put(8, mk(18'h7, 1'b0, '0));
    put(8, mk(18'h7, 1'b0, '0));
    fork
      put(8, mk(18'h17, 1'b0, '0));
    join_none
    @(negedge clk);
    #2 chk("held grant", 32'(grant[8]), 0);
    repeat (3) @(negedge clk);
    chk("stall on", 32'(stall), 1);
    put(9, mk(18'h1, 1'b0, '0));
    wait_go(4);
    repeat (4) @(negedge clk);
    chk("stall off", 32'(stall), 0);
    chk("order 1", 32'(gq[1].tag), 9);
    chk("order 2", 32'(gq[2].addr), 7);
    chk("order 3", 32'(gq[3].addr), 32'h17);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    chk("go after reset", 32'(mem.go), 0);
    repeat (3) @(negedge clk);
    t_prio();
    t_seq();
    t_perr();
    t_ecc();
    t_bank();
    final_report();
  end
endmodule
`default_nettype wire
